// ===== clg_consts.vh
`ifndef CLG_CONSTS_VH
`define CLG_CONSTS_VH

// number of input pins on the block
`define CLG_NUM_INPUTS 4

// width and encoding of the function selection
`define CLG_FN_W    3
`define CLG_FN_AND  3'h0
`define CLG_FN_OR   3'h1
`define CLG_FN_NAND 3'h2
`define CLG_FN_NOR  3'h3
`define CLG_FN_NOT  3'h4
`define CLG_FN_XOR  3'h5

// number of functions and their bit positions in the one-hot views
`define CLG_NUM_FN   6
`define CLG_HIT_AND  0
`define CLG_HIT_OR   1
`define CLG_HIT_NAND 2
`define CLG_HIT_NOR  3
`define CLG_HIT_NOT  4
`define CLG_HIT_XOR  5

// output level after reset
`define CLG_OUT_RESET 1'h0

// neutral seeds of the and and or chains
`define CLG_SEED_ON  1'h1
`define CLG_SEED_OFF 1'h0

`endif

// ===== clg_logic_gate.v
`timescale 1ns/1ps
// Notes on behaviour
// - four inputs, pin position never matters
// - no connected input keeps output off
// - AND: all connected on; unused count on
// - OR: on if any connected input on
// - OR: unused inputs count as off
// - NOT: output inverts the single connected input
// - XOR: on when two differ; unused counts on
// - NAND: on if any off; unused count on
// - NOR: on if all off; unused count off
`include "clg_consts.vh"

module clg_logic_gate
#(
  parameter N_IN = `CLG_NUM_INPUTS
)
(
  // clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // static configuration
  input  wire [`CLG_FN_W-1:0] fn_sel,
  input  wire [N_IN-1:0]   in_used,
  // binary inputs from upstream blocks, on/off only
  input  wire [N_IN-1:0]   in_val,
  // registered result
  output reg               out_q
);

  // unused pins are forced to the neutral level of each function
  wire [N_IN-1:0]          as_on;
  wire [N_IN-1:0]          as_off;
  // running chains across the pins, seeded with each neutral level
  wire [N_IN:0]            and_chain;
  wire [N_IN:0]            or_chain;
  wire [N_IN:0]            xor_chain;
  wire [N_IN:0]            used_chain;
  // summary of the connected pins
  wire                     any_used;
  wire                     and_all;
  wire                     or_any;
  wire                     odd_ones;
  // one result per function, all formed every cycle
  reg                      res_and;
  reg                      res_or;
  reg                      res_nand;
  reg                      res_nor;
  reg                      res_not;
  reg                      res_xor;
  wire [`CLG_NUM_FN-1:0]   fn_res;
  // one-hot view of the selection
  wire [`CLG_NUM_FN-1:0]   fn_hit;
  wire                     fn_known;
  reg                      out_d;

  // true when the selection names the given function code
  function sel_is;
    input [`CLG_FN_W-1:0] sel;
    input [`CLG_FN_W-1:0] code;
    begin
      sel_is = (sel == code);
    end
  endfunction

  // picks the result of the selected function; unknown codes give off
  function pick_result;
    input [`CLG_FN_W-1:0]   sel;
    input [`CLG_NUM_FN-1:0] res;
    begin
      case (sel)
        `CLG_FN_AND:
        begin
          pick_result = res[`CLG_HIT_AND];
        end
        `CLG_FN_OR:
        begin
          pick_result = res[`CLG_HIT_OR];
        end
        `CLG_FN_NAND:
        begin
          pick_result = res[`CLG_HIT_NAND];
        end
        `CLG_FN_NOR:
        begin
          pick_result = res[`CLG_HIT_NOR];
        end
        `CLG_FN_NOT:
        begin
          pick_result = res[`CLG_HIT_NOT];
        end
        `CLG_FN_XOR:
        begin
          pick_result = res[`CLG_HIT_XOR];
        end
        default:
        begin
          pick_result = `CLG_OUT_RESET;
        end
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < N_IN; g = g + 1)
    begin : g_pin
      // on-neutral view for and, nand and xor
      assign as_on[g]  = in_val[g] | ~in_used[g];
      // off-neutral view for or, nor and not
      assign as_off[g] = in_val[g] & in_used[g];
    end
  endgenerate

  // chains fold the pins one by one, so pin position never matters
  assign and_chain[0]  = `CLG_SEED_ON;
  assign or_chain[0]   = `CLG_SEED_OFF;
  assign xor_chain[0]  = `CLG_SEED_OFF;
  assign used_chain[0] = `CLG_SEED_OFF;

  generate
    for (g = 0; g < N_IN; g = g + 1)
    begin : g_fold
      assign and_chain[g+1]  = and_chain[g] & as_on[g];
      assign or_chain[g+1]   = or_chain[g] | as_off[g];
      assign xor_chain[g+1]  = xor_chain[g] ^ as_on[g];
      assign used_chain[g+1] = used_chain[g] | in_used[g];
    end
  endgenerate

  assign any_used = used_chain[N_IN];
  assign and_all  = and_chain[N_IN];
  assign or_any   = or_chain[N_IN];
  // with unused pins as on, two connected pins give a plain xor
  assign odd_ones = xor_chain[N_IN];

  always @*
  begin
    res_and = and_all;
  end

  always @*
  begin
    res_or = or_any;
  end

  always @*
  begin
    res_nand = ~and_all;
  end

  always @*
  begin
    res_nor = ~or_any;
  end

  // several connected pins act as nor; one pin is a plain inverter
  always @*
  begin
    res_not = ~or_any;
  end

  always @*
  begin
    res_xor = odd_ones;
  end

  assign fn_res[`CLG_HIT_AND]  = res_and;
  assign fn_res[`CLG_HIT_OR]   = res_or;
  assign fn_res[`CLG_HIT_NAND] = res_nand;
  assign fn_res[`CLG_HIT_NOR]  = res_nor;
  assign fn_res[`CLG_HIT_NOT]  = res_not;
  assign fn_res[`CLG_HIT_XOR]  = res_xor;

  // one-hot decode of the selection
  assign fn_hit[`CLG_HIT_AND]  = sel_is(fn_sel, `CLG_FN_AND);
  assign fn_hit[`CLG_HIT_OR]   = sel_is(fn_sel, `CLG_FN_OR);
  assign fn_hit[`CLG_HIT_NAND] = sel_is(fn_sel, `CLG_FN_NAND);
  assign fn_hit[`CLG_HIT_NOR]  = sel_is(fn_sel, `CLG_FN_NOR);
  assign fn_hit[`CLG_HIT_NOT]  = sel_is(fn_sel, `CLG_FN_NOT);
  assign fn_hit[`CLG_HIT_XOR]  = sel_is(fn_sel, `CLG_FN_XOR);
  // codes outside the list give an off output rather than a guess
  assign fn_known = |fn_hit;

  always @*
  begin
    out_d = `CLG_OUT_RESET;
    if (!any_used)
    begin
      out_d = `CLG_OUT_RESET;
    end
    else if (!fn_known)
    begin
      out_d = `CLG_OUT_RESET;
    end
    else
    begin
      out_d = pick_result(fn_sel, fn_res);
    end
  end

  // one register stage keeps the output free of decode glitches
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= `CLG_OUT_RESET;
    end
    else
    begin
      out_q <= out_d;
    end
  end

endmodule // clg_logic_gate

// ===== clg_src.sv
`timescale 1ns/1ps
// upstream blocks: plain on/off lines only
module clg_src
(
  input  wire [3:0] v,
  output wire [3:0] in_val
);
  assign in_val = v;
endmodule // clg_src

// ===== clg_chk_properties.sv
`timescale 1ns/1ps
module clg_chk
(
  input wire       clk,
  input wire       rst_n,
  input wire [2:0] fn_sel,
  input wire [3:0] in_used,
  input wire [3:0] in_val,
  input wire       out_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_none_off: assert property (in_used == 0 |=> !out_q) else $error("out on");
  a_or_fn: assert property (fn_sel == 3'h1 |=> out_q == |($past(in_val) & $past(in_used)))
    else $error("or result wrong");
  a_and_fn: assert property (fn_sel == 3'h0 && in_used != 4'h0 |=> out_q == &($past(in_val) | ~$past(in_used)))
    else $error("and result wrong");
  a_nand_fn: assert property (fn_sel == 3'h2 && in_used != 4'h0 |=> out_q == !(&($past(in_val) | ~$past(in_used))))
    else $error("nand result wrong");
  a_nor_fn: assert property (fn_sel == 3'h3 && in_used != 4'h0 |=> out_q == !(|($past(in_val) & $past(in_used))))
    else $error("nor result wrong");
  a_not_fn: assert property (fn_sel == 3'h4 && $onehot(in_used) |=> out_q == !(|($past(in_val) & $past(in_used))))
    else $error("not result wrong");
  a_xor_fn: assert property (fn_sel == 3'h5 && $countones(in_used) == 2 |=> out_q == ^($past(in_val) & $past(in_used)))
    else $error("xor result wrong");
  a_unknown_off: assert property (fn_sel > 3'h5 |=> !out_q)
    else $error("unknown function drove output on");
endmodule // clg_chk
bind clg_logic_gate clg_chk chk_u (.*);

// ===== configurable_logic_gate_block_bench.sv
`timescale 1ns/1ps
module configurable_logic_gate_block_bench;
  reg         clk = 0, rst_n = 0;
  reg  [2:0]  fn_sel = 0;
  reg  [3:0]  in_used = 0, v = 0;
  wire [3:0]  in_val;
  wire        out_q;
  integer     n_mismatch = 0, total_checks = 0;
  always #4 clk = ~clk;
  clg_src src_u (.v(v), .in_val(in_val));
  clg_logic_gate dut_u (.clk(clk), .rst_n(rst_n), .fn_sel(fn_sel), .in_used(in_used), .in_val(in_val), .out_q(out_q));
  task chk(input logic e);
    total_checks++;
    if (out_q !== e)
    begin
      n_mismatch++;
      $display("[FAIL] out_q exp %b got %b", e, out_q);
    end
  endtask
  // inputs change on one falling edge; the next falling edge sees the registered result
  task drive(input [2:0] f, input [3:0] u, input [3:0] x);
    @(negedge clk);
    fn_sel = f;
    in_used = u;
    v = x;
    @(negedge clk);
  endtask
  task run_and;
    drive(3'h0, 4'h3, 4'h3); chk(1'h1);
    drive(3'h0, 4'h3, 4'h2); chk(1'h0);
    drive(3'h0, 4'hf, 4'h0); chk(1'h0);
    drive(3'h0, 4'h8, 4'h8); chk(1'h1);
    drive(3'h0, 4'h1, 4'h1); chk(1'h1);
  endtask
  task run_or;
    drive(3'h1, 4'h1, 4'h2); chk(1'h0);
    drive(3'h1, 4'hc, 4'h4); chk(1'h1);
    drive(3'h1, 4'hc, 4'h0); chk(1'h0);
    drive(3'h1, 4'h3, 4'hc); chk(1'h0);
  endtask
  task run_nand;
    drive(3'h2, 4'h3, 4'h3); chk(1'h0);
    drive(3'h2, 4'h3, 4'h2); chk(1'h1);
    drive(3'h2, 4'h3, 4'hc); chk(1'h1);
  endtask
  task run_nor;
    drive(3'h3, 4'hc, 4'h0); chk(1'h1);
    drive(3'h3, 4'hc, 4'h8); chk(1'h0);
    drive(3'h3, 4'h3, 4'hc); chk(1'h1);
  endtask
  task run_not;
    drive(3'h4, 4'h8, 4'h0); chk(1'h1);
    drive(3'h4, 4'h8, 4'h8); chk(1'h0);
    drive(3'h4, 4'h2, 4'hd); chk(1'h1);
  endtask
  task run_xor;
    drive(3'h5, 4'h3, 4'h1); chk(1'h1);
    drive(3'h5, 4'h3, 4'h3); chk(1'h0);
    drive(3'h5, 4'h3, 4'h0); chk(1'h0);
    drive(3'h5, 4'h6, 4'h4); chk(1'h1);
  endtask
  task run_none_used;
    drive(3'h0, 4'hf, 4'hf); chk(1'h1);
    drive(3'h0, 4'h0, 4'hf); chk(1'h0);
    drive(3'h4, 4'h0, 4'h0); chk(1'h0);
    drive(3'h3, 4'h0, 4'h0); chk(1'h0);
  endtask
  task run_unknown_fn;
    drive(3'h5, 4'h3, 4'h1); chk(1'h1);
    drive(3'h6, 4'h3, 4'h1); chk(1'h0);
    drive(3'h7, 4'hf, 4'hf); chk(1'h0);
  endtask
  task run_mid_reset;
    drive(3'h0, 4'hf, 4'hf); chk(1'h1);
    @(negedge clk);
    rst_n = 0;
    #1;
    chk(1'h0);
    repeat (3) @(negedge clk);
    chk(1'h0);
    rst_n = 1;
    @(negedge clk);
    chk(1'h1);
  endtask
  task test_done;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    chk(1'h0);
    rst_n = 1;
    run_and;
    run_or;
    run_nand;
    run_nor;
    run_not;
    run_xor;
    run_none_used;
    run_unknown_fn;
    run_mid_reset;
    test_done;
  end
  // the scenarios take about 70 cycles; this leaves a wide margin
  initial
  begin
    #4000;
    n_mismatch++;
    test_done;
  end
endmodule // configurable_logic_gate_block_bench
